// ---- pkg/kpi_defines.svh ----
// register offsets, field positions, reset values and sizes of the pin-change interrupt unit
// assumes: included by the package and by the design, once per compile unit
`ifndef KPI_DEFINES_SVH
`define KPI_DEFINES_SVH
`define KPI_MAX_LINES 8
`define KPI_OFS_SC 32'h0000_0000
`define KPI_OFS_PE 32'h0000_0004
`define KPI_OFS_ES 32'h0000_0008
`define KPI_SC_MODE 0
`define KPI_SC_IE 1
`define KPI_SC_ACK 2
`define KPI_SC_FLAG 3
`define KPI_RST_SC 8'h00
`define KPI_RST_PE 8'h00
`define KPI_RST_ES 8'h00
`endif

// ---- pkg/kpi_pkg.sv ----
// types of the pin-change interrupt unit: bus carriers and the state record
// assumes: kpi_defines.svh on the include path
`default_nettype none
`include "kpi_defines.svh"
package kpi_pkg;
  typedef logic [`KPI_MAX_LINES-1:0] kpi_line_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } kpi_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } kpi_wb_rsp_t;
  typedef struct packed {
    kpi_line_t s1;
    kpi_line_t s2;
    kpi_line_t s3;
    kpi_line_t flt;
    kpi_line_t act_prev;
    kpi_line_t pe;
    kpi_line_t pol;
    logic mode;
    logic ie;
    logic flag;
    logic armed;
    logic irq;
    logic wake;
    kpi_wb_rsp_t rsp;
  } kpi_state_t;
endpackage
`default_nettype wire

// ---- src/kpi_top.sv ----
// pin-change interrupt unit with a classic wishbone register slave
// assumes: one clock, synchronous active-low reset, asynchronous key lines
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "kpi_defines.svh"
module kpi_top
  import kpi_pkg::*;
#(
  parameter int NUM_LINES = `KPI_MAX_LINES
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire kpi_wb_req_t wb_req,
  output var kpi_wb_rsp_t wb_rsp,
  input wire kpi_line_t key_input_lines,
  output logic irq_o,
  output logic wake_o
);
  // each copy keeps its own three registers; NUM_LINES trims unused lines
  localparam kpi_line_t LINE_MASK = kpi_line_t'((9'h001 << NUM_LINES) - 9'h001);
  localparam logic [7:0] RST_SC = `KPI_RST_SC;

  kpi_state_t st_ff;
  kpi_state_t nxt_st;
  kpi_line_t act;
  kpi_line_t flt_upd;
  kpi_line_t en_act;
  logic any_act;
  logic edge_det;
  logic set_evt;
  logic acc;
  logic wr;
  logic ack_wr;

  genvar gi;
  generate
    for (gi = 0; gi < `KPI_MAX_LINES; gi++)
    begin : g_line
      // filtered level follows only once the second and third stages agree
      assign flt_upd[gi] = (st_ff.s2[gi] == st_ff.s3[gi]) ? st_ff.s2[gi] : st_ff.flt[gi];
      // polarity 1 makes high the active level, 0 makes low active
      assign act[gi] = st_ff.flt[gi] ~^ st_ff.pol[gi];
    end
  endgenerate

  // detection never looks at a debug or low-power state, so it runs the same in all
  assign en_act = act & st_ff.pe & LINE_MASK;
  assign any_act = |en_act;
  assign edge_det = st_ff.armed & (|(en_act & ~st_ff.act_prev));
  assign set_evt = edge_det | (st_ff.mode & any_act);
  assign acc = wb_req.cyc & wb_req.stb & ~st_ff.rsp.ack;
  assign wr = acc & wb_req.we & wb_req.sel[0];
  assign ack_wr = wr & (wb_req.adr == `KPI_OFS_SC) & wb_req.dat[`KPI_SC_ACK];

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = key_input_lines;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.flt = flt_upd;
    nxt_st.act_prev = en_act;
    // re-arm only when every enabled line is back at its inactive level
    if (!any_act)
    begin
      nxt_st.armed = 1'b1;
    end
    else if (edge_det)
    begin
      nxt_st.armed = 1'b0;
    end
    if (wr)
    begin
      unique case (wb_req.adr)
        `KPI_OFS_SC:
        begin
          nxt_st.mode = wb_req.dat[`KPI_SC_MODE];
          nxt_st.ie = wb_req.dat[`KPI_SC_IE];
        end
        `KPI_OFS_PE:
        begin
          nxt_st.pe = wb_req.dat[`KPI_MAX_LINES-1:0] & LINE_MASK;
        end
        `KPI_OFS_ES:
        begin
          nxt_st.pol = wb_req.dat[`KPI_MAX_LINES-1:0] & LINE_MASK;
        end
        default:
        begin
          nxt_st.mode = st_ff.mode;
        end
      endcase
    end
    // a new event wins over the acknowledge; in level mode a held level keeps the flag up
    nxt_st.flag = set_evt | (st_ff.flag & ~ack_wr);
    nxt_st.irq = nxt_st.flag & nxt_st.ie;
    // wake request also follows a held active level so a stopped core can leave
    nxt_st.wake = nxt_st.ie & (nxt_st.flag | any_act);
    nxt_st.rsp.ack = acc;
    nxt_st.rsp.dat = 32'h0000_0000;
    if (acc && !wb_req.we)
    begin
      unique case (wb_req.adr)
        `KPI_OFS_SC:
        begin
          nxt_st.rsp.dat[`KPI_SC_FLAG] = st_ff.flag;
          nxt_st.rsp.dat[`KPI_SC_IE] = st_ff.ie;
          nxt_st.rsp.dat[`KPI_SC_MODE] = st_ff.mode;
        end
        `KPI_OFS_PE:
        begin
          nxt_st.rsp.dat[`KPI_MAX_LINES-1:0] = st_ff.pe;
        end
        `KPI_OFS_ES:
        begin
          nxt_st.rsp.dat[`KPI_MAX_LINES-1:0] = st_ff.pol;
        end
        default:
        begin
          nxt_st.rsp.dat = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_ff <= '0;
      st_ff.mode <= RST_SC[`KPI_SC_MODE];
      st_ff.ie <= RST_SC[`KPI_SC_IE];
      st_ff.pe <= `KPI_RST_PE;
      st_ff.pol <= `KPI_RST_ES;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign wb_rsp = st_ff.rsp;
  assign irq_o = st_ff.irq;
  assign wake_o = st_ff.wake;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence bus_req_s;
    wb_req.cyc && wb_req.stb && !st_ff.rsp.ack;
  endsequence

  sequence ack_write_s;
    bus_req_s ##0 (wb_req.we && wb_req.sel[0] && wb_req.adr == `KPI_OFS_SC
      && wb_req.dat[`KPI_SC_ACK]);
  endsequence

  sequence quiet_s;
    (st_ff.pe == '0) [*2];
  endsequence

  sequence rd_req_s;
    bus_req_s ##0 !wb_req.we;
  endsequence

  sequence wr_req_s;
    bus_req_s ##0 (wb_req.we && wb_req.sel[0]);
  endsequence

  AST_BUS_ACK: assert property (bus_req_s |=> wb_rsp.ack ##1 !wb_rsp.ack)
    else $error("bus request not answered in one cycle");

  AST_DISABLED_QUIET: assert property (quiet_s ##0 !st_ff.flag ##0 !wb_req.we |=> !st_ff.flag)
    else $error("flag set with every line disabled");

  AST_POLARITY: assert property (edge_det |-> |(st_ff.pe & (st_ff.flt ~^ st_ff.pol)))
    else $error("edge taken on a line at its inactive level");

  AST_LEVEL_SET: assert property (st_ff.mode && any_act |=> st_ff.flag)
    else $error("held active level did not set flag in level mode");

  AST_IRQ_GATE: assert property (##1 irq_o == $past(nxt_st.flag && nxt_st.ie))
    else $error("request output disagrees with flag and enable");

  AST_WAKE: assert property (st_ff.ie && set_evt && !wr |=> wake_o && irq_o)
    else $error("event with enable set did not raise wake and request");

  AST_WAKE_LEVEL: assert property (st_ff.ie && any_act && !wr |=> wake_o)
    else $error("active enabled line with enable set did not raise wake");

  AST_NO_REARM: assert property (edge_det ##1 any_act |-> !edge_det)
    else $error("new edge taken before lines returned inactive");

  AST_EDGE_SETS: assert property (edge_det |=> st_ff.flag && (irq_o == st_ff.ie))
    else $error("edge did not set flag");

  AST_FLAG_WRITE: assert property (
    bus_req_s ##0 (wb_req.we && wb_req.adr == `KPI_OFS_SC && wb_req.dat[`KPI_SC_FLAG]
      && !wb_req.dat[`KPI_SC_ACK] && !st_ff.flag && !set_evt) |=> !st_ff.flag)
    else $error("write to flag bit changed flag");

  AST_ACK_CLEAR: assert property (ack_write_s ##0 !set_evt |=> !st_ff.flag)
    else $error("acknowledge did not clear flag");

  AST_ACK_HOLD: assert property (ack_write_s ##0 (st_ff.mode && any_act) |=> st_ff.flag)
    else $error("flag cleared while a line still active in level mode");

  AST_SYNC: assert property ((st_ff.s2 == st_ff.s3) |=> st_ff.flt == $past(st_ff.s2))
    else $error("filtered line did not follow agreeing stages");

  // register bus: answer shape, read-back and where writes land

  property ack_pulse_p;
    wb_rsp.ack |=> !wb_rsp.ack;
  endproperty
  AST_ACK_PULSE: assert property (ack_pulse_p)
    else $error("acknowledge stood for more than one cycle");

  property rd_idle_p;
    !wb_rsp.ack |-> wb_rsp.dat == 32'h0000_0000;
  endproperty
  AST_RD_IDLE: assert property (rd_idle_p)
    else $error("read data not zero outside an acknowledge");

  property rd_sc_p;
    rd_req_s ##0 (wb_req.adr == `KPI_OFS_SC) |=>
      wb_rsp.dat == {28'h000_0000, $past(st_ff.flag), 1'b0, $past(st_ff.ie), $past(st_ff.mode)};
  endproperty
  AST_RD_SC: assert property (rd_sc_p)
    else $error("status read does not show flag, enable and mode");

  property rd_pe_p;
    rd_req_s ##0 (wb_req.adr == `KPI_OFS_PE) |=> wb_rsp.dat == {24'h00_0000, $past(st_ff.pe)};
  endproperty
  AST_RD_PE: assert property (rd_pe_p)
    else $error("line enable read does not match the enables");

  property rd_es_p;
    rd_req_s ##0 (wb_req.adr == `KPI_OFS_ES) |=> wb_rsp.dat == {24'h00_0000, $past(st_ff.pol)};
  endproperty
  AST_RD_ES: assert property (rd_es_p)
    else $error("polarity read does not match the polarity bits");

  property wr_sc_p;
    wr_req_s ##0 (wb_req.adr == `KPI_OFS_SC) |=>
      st_ff.mode == $past(wb_req.dat[`KPI_SC_MODE])
      && st_ff.ie == $past(wb_req.dat[`KPI_SC_IE]);
  endproperty
  AST_WR_SC: assert property (wr_sc_p)
    else $error("status write did not set mode and enable");

  property wr_pe_p;
    wr_req_s ##0 (wb_req.adr == `KPI_OFS_PE) |=>
      st_ff.pe == ($past(wb_req.dat[`KPI_MAX_LINES-1:0]) & LINE_MASK);
  endproperty
  AST_WR_PE: assert property (wr_pe_p)
    else $error("line enable write did not land");

  property wr_es_p;
    wr_req_s ##0 (wb_req.adr == `KPI_OFS_ES) |=>
      st_ff.pol == ($past(wb_req.dat[`KPI_MAX_LINES-1:0]) & LINE_MASK);
  endproperty
  AST_WR_ES: assert property (wr_es_p)
    else $error("polarity write did not land");

  property wr_other_p;
    wr_req_s ##0 (wb_req.adr != `KPI_OFS_SC && wb_req.adr != `KPI_OFS_PE
      && wb_req.adr != `KPI_OFS_ES) |=>
      $stable(st_ff.pe) && $stable(st_ff.pol) && $stable(st_ff.mode) && $stable(st_ff.ie);
  endproperty
  AST_WR_UNMAPPED: assert property (wr_other_p)
    else $error("write to an unmapped address changed a register");

  // line path and detection

  property sync_chain_p;
    ##1 st_ff.s2 == $past(st_ff.s1) && st_ff.s3 == $past(st_ff.s2);
  endproperty
  AST_SYNC_CHAIN: assert property (sync_chain_p)
    else $error("synchroniser stages did not shift");

  property flt_hold_p;
    st_ff.s2 != st_ff.s3 |=> $stable(st_ff.flt);
  endproperty
  AST_FLT_HOLD: assert property (flt_hold_p)
    else $error("filtered line moved while stages disagreed");

  property rearm_p;
    nrst && !any_act |=> st_ff.armed;
  endproperty
  AST_REARM: assert property (rearm_p)
    else $error("detector not armed with every enabled line inactive");

  property edge_only_p;
    !st_ff.mode && !edge_det |=> !$rose(st_ff.flag);
  endproperty
  AST_EDGE_ONLY: assert property (edge_only_p)
    else $error("flag rose in edge mode without an edge");

  property flag_sticky_p;
    st_ff.flag && !ack_wr |=> st_ff.flag;
  endproperty
  AST_FLAG_STICKY: assert property (flag_sticky_p)
    else $error("flag dropped without an acknowledge");

  property irq_level_p;
    irq_o == (st_ff.flag && st_ff.ie);
  endproperty
  AST_IRQ_LEVEL: assert property (irq_level_p)
    else $error("request differs from flag gated by enable");

  property wake_gate_p;
    wake_o |-> st_ff.ie;
  endproperty
  AST_WAKE_GATE: assert property (wake_gate_p)
    else $error("wake request raised with enable clear");

endmodule
`default_nettype wire

// ---- verification/kpi_key_model.sv ----
// key switch model: drives the input lines from levels the bench commands
// assumes: lines idle high, as with pull-ups on open switches
`timescale 1ns/1ps
`default_nettype none
module kpi_key_model
  import kpi_pkg::*;
(
  input wire logic clk,
  input wire kpi_line_t level,
  output var kpi_line_t key_input_lines
);
  always_ff @(posedge clk)
  begin
    key_input_lines <= level;
  end
endmodule
`default_nettype wire

// ---- verification/test_kpi_top.sv ----
// self-checking bench of the pin-change interrupt unit
// assumes: kpi_pkg compiled first, key model drives the lines
`timescale 1ns/1ps
`default_nettype none
module test_kpi_top
  import kpi_pkg::*;
;
  logic clk;
  logic nrst;
  kpi_wb_req_t req;
  kpi_wb_rsp_t rsp;
  kpi_line_t lvl;
  kpi_line_t keys;
  logic irq;
  logic wake;
  logic [31:0] q[$];
  logic [31:0] s;
  int err_count;
  int samples_checked;
  kpi_top kpi_top_inst (.clk(clk), .nrst(nrst), .wb_req(req), .wb_rsp(rsp),
    .key_input_lines(keys), .irq_o(irq), .wake_o(wake));
  kpi_key_model kpi_key_model_inst (.clk(clk), .level(lvl), .key_input_lines(keys));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up();
    $display("errors=%0d checked=%0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // read data is compared at the ack edge against the oldest note
  always @(posedge clk)
  begin
    if (rsp.ack === 1'b1 && req.we === 1'b0 && q.size() > 0)
      cmp(rsp.dat, q.pop_front());
  end
  task wb(input logic w, input logic [31:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, w, a, 4'hf, {24'h0, d}};
    if (!w)
      q.push_back({24'h0, d});
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.ack !== 1'b1 && n < 20);
    if (rsp.ack !== 1'b1)
    begin
      err_count++;
      wrap_up();
    end
    else
    begin
      req <= '0;
      @(posedge clk);
    end
  endtask
  task settle();
    repeat (8) @(posedge clk);
  endtask
  function automatic logic [7:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  initial
  begin
    s = 32'h0000_005d;
    err_count = 0;
    samples_checked = 0;
    req = '0;
    lvl = 8'hff;
    nrst = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    wb(0, 32'h0, 8'h00);
    wb(0, 32'h4, 8'h00);
    wb(0, 32'h8, 8'h00);
    wb(0, 32'h10, 8'h00);
    wb(1, 32'h4, 8'h01);
    wb(1, 32'h0, 8'h06);
    settle();
    repeat (6)
    begin
      lvl <= {rnd() | 8'h01};
      settle();
      cmp_pin(irq, 1'b0);
    end
    lvl <= 8'hff;
    settle();
    lvl <= 8'hfe;
    settle();
    cmp_pin(irq, 1'b1);
    wb(0, 32'h0, 8'h0a);
    wb(1, 32'h0, 8'h0a);
    wb(0, 32'h0, 8'h0a);
    wb(1, 32'h0, 8'h06);
    wb(0, 32'h0, 8'h02);
    cmp_pin(irq, 1'b0);
    wb(1, 32'h0, 8'h0a);
    wb(0, 32'h0, 8'h02);
    wb(1, 32'h10, 8'hff);
    wb(0, 32'h4, 8'h01);
    wb(1, 32'h0, 8'h07);
    settle();
    wb(0, 32'h0, 8'h0b);
    lvl <= 8'hff;
    settle();
    wb(1, 32'h0, 8'h07);
    wb(0, 32'h0, 8'h03);
    lvl <= 8'hfe;
    wb(1, 32'h8, 8'h01);
    settle();
    wb(1, 32'h0, 8'h07);
    wb(0, 32'h0, 8'h03);
    lvl <= 8'hff;
    settle();
    wb(0, 32'h0, 8'h0b);
    cmp_pin(irq, 1'b1);
    wb(1, 32'h0, 8'h05);
    settle();
    cmp_pin(irq, 1'b0);
    cmp_pin(wake, 1'b0);
    wb(1, 32'h0, 8'h03);
    settle();
    cmp_pin(wake, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
